// File: logic/dsta_arbiter.sv
`timescale 1ns/1ps
`include "dsta_regs.svh"
module dsta_arbiter (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsta_pkg::dsta_sense_s sense,
  input wire logic [9:0] ext_hi_derate,
  input wire logic [9:0] ext_lo_derate,
  output logic [15:0] final_torque_command,
  output logic [4:0] op_state,
  output logic [1:0] drive_mode,
  output logic start_safe,
  output logic [1:0] run_mode_state
);
  import dsta_pkg::*;

  // ==========================================================
  // Input synchronisers.
  dsta_sense_s sense_meta;
  dsta_sense_s s;
  logic [19:0] der_meta;
  logic [19:0] der_sync;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_meta <= '0;
      s <= '0;
      der_meta <= '0;
      der_sync <= '0;
    end else begin
      sense_meta <= sense;
      s <= sense_meta;
      der_meta <= {ext_hi_derate, ext_lo_derate};
      der_sync <= der_meta;
    end
  end

  // ==========================================================
  // Registers.
  logic [1:0] perf_level;
  logic run_enable;
  logic creep_enable;
  logic regen_enable;
  logic regen_axis_select;
  logic regen_needs_brake;
  logic [15:0] park_entry_speed_limit;
  logic [15:0] gear_change_speed_limit;
  logic [7:0] launch_pedal_max;
  logic [7:0] launch_pedal_min;
  logic [7:0] creep_pedal_limit;
  logic [7:0] regen_pedal_limit;
  logic [15:0] creep_speed_off;
  logic [15:0] creep_speed_on;
  logic [15:0] regen_speed_minimum;
  logic [15:0] regen_cut_on;
  logic [15:0] regen_cut_off;
  logic [15:0] global_cap_hi;
  logic [15:0] global_cap_lo;
  logic [9:0] motoring_derate_factor;
  logic [9:0] generating_derate_factor;
  logic [15:0] torque_rise_rate;
  logic [15:0] torque_fall_rate;
  logic [15:0] map_torque;
  logic [9:0] trim_factor;
  logic [7:0] creep_torque;
  logic [7:0] backward_torque;
  logic signed [15:0] pedal_scale [4];
  logic signed [15:0] regen_torque_value;

  wire logic wr_en = psel && penable && pwrite;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      perf_level <= '0;
      run_enable <= 1'b0;
      creep_enable <= 1'b0;
      regen_enable <= 1'b0;
      regen_axis_select <= 1'b0;
      regen_needs_brake <= 1'b0;
      park_entry_speed_limit <= `DSTA_SPD_ZERO_RST;
      gear_change_speed_limit <= `DSTA_SPD_LO_RST;
      launch_pedal_max <= '0;
      launch_pedal_min <= '0;
      creep_pedal_limit <= '0;
      regen_pedal_limit <= '0;
      creep_speed_off <= '0;
      creep_speed_on <= '0;
      regen_speed_minimum <= '0;
      regen_cut_on <= '0;
      regen_cut_off <= '0;
      global_cap_hi <= `DSTA_CAP_RST;
      global_cap_lo <= `DSTA_CAP_RST;
      motoring_derate_factor <= `DSTA_FULL_SCALE;
      generating_derate_factor <= `DSTA_FULL_SCALE;
      torque_rise_rate <= `DSTA_RATE_RST;
      torque_fall_rate <= `DSTA_RATE_RST;
      map_torque <= '0;
      trim_factor <= `DSTA_FULL_SCALE;
      creep_torque <= '0;
      backward_torque <= '0;
    end else if (wr_en) begin
      case (paddr)
        `DSTA_OFF_CTRL: begin
          perf_level <= pwdata[1:0];
          run_enable <= pwdata[2];
          creep_enable <= pwdata[3];
          regen_enable <= pwdata[4];
          regen_axis_select <= pwdata[5];
          regen_needs_brake <= pwdata[6];
        end
        `DSTA_OFF_SPEED: begin
          park_entry_speed_limit <= pwdata[15:0];
          gear_change_speed_limit <= pwdata[31:16];
        end
        `DSTA_OFF_PEDAL: begin
          launch_pedal_max <= pwdata[7:0];
          launch_pedal_min <= pwdata[15:8];
          creep_pedal_limit <= pwdata[23:16];
          regen_pedal_limit <= pwdata[31:24];
        end
        `DSTA_OFF_CREEP: begin
          creep_speed_off <= pwdata[15:0];
          creep_speed_on <= pwdata[31:16];
        end
        `DSTA_OFF_REGEN: begin
          regen_cut_off <= pwdata[15:0];
          regen_cut_on <= pwdata[31:16];
        end
        `DSTA_OFF_CAP: begin
          global_cap_hi <= pwdata[15:0];
          global_cap_lo <= pwdata[31:16];
        end
        `DSTA_OFF_DERATE: begin
          motoring_derate_factor <= pwdata[9:0];
          generating_derate_factor <= pwdata[25:16];
        end
        `DSTA_OFF_RATE: begin
          torque_rise_rate <= pwdata[15:0];
          torque_fall_rate <= pwdata[31:16];
        end
        `DSTA_OFF_MAPS: begin
          map_torque <= pwdata[15:0];
          trim_factor <= pwdata[25:16];
        end
        `DSTA_OFF_STATUS: begin
          creep_torque <= pwdata[7:0];
          backward_torque <= pwdata[15:8];
          regen_speed_minimum <= pwdata[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  // Per-level pedal scale, written at offset TORQUE with level in [17:16].
  for (genvar g = 0; g < 4; g++) begin : g_pedal
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pedal_scale[g] <= 16'sh0100;
      end else if (wr_en && paddr == `DSTA_OFF_TORQUE &&
                   pwdata[17:16] == 2'(g)) begin
        pedal_scale[g] <= pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // Drive mode arbitration.
  wire logic plug = s.charge_plug_present;
  wire logic to_park = s.mode_request == DSTA_PARK;
  wire logic in_park = drive_mode == DSTA_PARK;
  logic mode_ok;
  always_comb begin
    mode_ok = 1'b0;
    if (s.mode_request != drive_mode) begin
      if (plug && (in_park || to_park)) begin
        mode_ok = 1'b0;
      end else if (in_park) begin
        mode_ok = s.brake_pressed &&
                  s.vehicle_speed < gear_change_speed_limit;
      end else if (to_park) begin
        mode_ok = s.vehicle_speed < park_entry_speed_limit;
      end else begin
        mode_ok = s.vehicle_speed < gear_change_speed_limit;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_mode <= DSTA_PARK;
    end else if (mode_ok) begin
      drive_mode <= s.mode_request;
    end
  end

  // ==========================================================
  // Start-safe and operating state.
  wire logic pedal_in_window = s.pedal_position >= launch_pedal_min &&
                               s.pedal_position <= launch_pedal_max;
  wire logic next_start_safe = !s.insulation_fault && s.brake_pressed &&
      !plug && (in_park || drive_mode == DSTA_NEUT) &&
      pedal_in_window;
  wire logic can_torque = run_mode_state == 2'h2 &&
      (drive_mode == DSTA_REV || drive_mode == DSTA_DRIVE);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_safe <= 1'b0;
      run_mode_state <= 2'h0;
      op_state <= 5'h01;
    end else begin
      start_safe <= next_start_safe;
      if (run_mode_state == 2'h0 && start_safe) begin
        run_mode_state <= 2'h2;
      end else if (!run_enable) begin
        run_mode_state <= 2'h0;
      end
      // Walk the startup and shutdown ladder one step at a time; some steps wait on a condition, others are unconditional.
      case (op_state)
        5'h01: if (run_enable) op_state <= 5'h02;
        5'h02: if (!s.insulation_fault) op_state <= 5'h03;
        5'h03: op_state <= 5'h04;
        5'h04: if (start_safe) op_state <= 5'h05;
        5'h05: if (!run_enable) op_state <= 5'h06;
        5'h06: op_state <= 5'h0b;
        5'h0b: op_state <= 5'h0c;
        5'h0c: if (s.motor_speed == '0) op_state <= 5'h0d;
        5'h0d: op_state <= 5'h0e;
        5'h0e: if (run_enable) op_state <= 5'h01;
        default: op_state <= 5'h01;
      endcase
    end
  end

  // ==========================================================
  // Creep and regen hysteresis.
  logic creep_allowed;
  logic regen_allowed;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      creep_allowed <= 1'b1;
      regen_allowed <= 1'b0;
    end else begin
      if (s.vehicle_speed > creep_speed_off) creep_allowed <= 1'b0;
      else if (s.vehicle_speed < creep_speed_on)
        creep_allowed <= 1'b1;
      if (s.motor_speed < regen_cut_on) regen_allowed <= 1'b0;
      else if (s.motor_speed > regen_cut_off)
        regen_allowed <= 1'b1;
    end
  end

  // ==========================================================
  // Torque shaping.
  wire logic [7:0] regen_axis = regen_axis_select ?
      s.regen_axis_input_b : s.regen_axis_input_a;
  wire logic regen_active = regen_enable && regen_allowed &&
      s.vehicle_speed > regen_speed_minimum &&
      s.pedal_position < regen_pedal_limit &&
      (!regen_needs_brake || s.brake_pressed);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regen_torque_value <= '0;
    end else begin
      regen_torque_value <= -$signed({8'h00, regen_axis}) -
          $signed({8'h00, s.motor_speed[15:8]});
    end
  end

  logic signed [31:0] base;
  logic signed [31:0] capped;
  logic signed [31:0] next_cmd;
  logic signed [31:0] derated;
  logic [9:0] hi_f;
  logic [9:0] lo_f;
  logic signed [15:0] cmd;
  always_comb begin
    base = ($signed({16'h0, map_torque}) *
            pedal_scale[perf_level]) >>> 8;
    base = (base * $signed({22'h0, trim_factor})) >>> 8;
    if (drive_mode == DSTA_REV) begin
      base = -$signed({24'h0, backward_torque});
    end else if (creep_enable && creep_allowed &&
                 s.pedal_position < creep_pedal_limit) begin
      base = $signed({24'h0, creep_torque});
    end
    if (regen_active) base = 32'(regen_torque_value);
    if (!can_torque) base = '0;
    capped = base;
    if (capped > $signed({16'h0, global_cap_hi}))
      capped = $signed({16'h0, global_cap_hi});
    if (capped < -$signed({16'h0, global_cap_lo}))
      capped = -$signed({16'h0, global_cap_lo});
    next_cmd = capped;
    if (capped > 32'(cmd) + $signed({16'h0, torque_rise_rate}))
      next_cmd = 32'(cmd) + $signed({16'h0, torque_rise_rate});
    else if (capped < 32'(cmd) - $signed({16'h0, torque_fall_rate}))
      next_cmd = 32'(cmd) - $signed({16'h0, torque_fall_rate});
    hi_f = motoring_derate_factor < der_sync[19:10] ?
           motoring_derate_factor : der_sync[19:10];
    lo_f = generating_derate_factor < der_sync[9:0] ?
           generating_derate_factor : der_sync[9:0];
    if (hi_f > `DSTA_FULL_SCALE) hi_f = `DSTA_FULL_SCALE;
    if (lo_f > `DSTA_FULL_SCALE) lo_f = `DSTA_FULL_SCALE;
    if (next_cmd >= 0)
      derated = (next_cmd * $signed({22'h0, hi_f})) >>> 8;
    else
      derated = (next_cmd * $signed({22'h0, lo_f})) >>> 8;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
      final_torque_command <= '0;
    end else begin
      cmd <= 16'(next_cmd);
      final_torque_command <= 16'(derated);
    end
  end

  // ==========================================================
  // APB read side, zero wait states.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `DSTA_OFF_TORQUE);
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `DSTA_OFF_CTRL: prdata <= {25'h0, regen_needs_brake,
              regen_axis_select, regen_enable, creep_enable,
              run_enable, perf_level};
          `DSTA_OFF_SPEED: prdata <= {gear_change_speed_limit,
              park_entry_speed_limit};
          `DSTA_OFF_PEDAL: prdata <= {regen_pedal_limit, creep_pedal_limit,
              launch_pedal_min, launch_pedal_max};
          `DSTA_OFF_CREEP: prdata <= {creep_speed_on, creep_speed_off};
          `DSTA_OFF_REGEN: prdata <= {regen_cut_on, regen_cut_off};
          `DSTA_OFF_CAP: prdata <= {global_cap_lo, global_cap_hi};
          `DSTA_OFF_DERATE: prdata <= {6'h0, generating_derate_factor,
              6'h0, motoring_derate_factor};
          `DSTA_OFF_RATE: prdata <= {torque_fall_rate, torque_rise_rate};
          `DSTA_OFF_MAPS: prdata <= {6'h0, trim_factor, map_torque};
          `DSTA_OFF_STATUS: prdata <= {regen_speed_minimum, backward_torque,
              creep_torque};
          `DSTA_OFF_TORQUE: prdata <= {final_torque_command, 3'h0,
              op_state, 2'h0, run_mode_state, drive_mode,
              start_safe, regen_active};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule

// File: inc/dsta_regs.svh
`ifndef DSTA_REGS_SVH
`define DSTA_REGS_SVH
`define DSTA_OFF_CTRL 12'h000
`define DSTA_OFF_SPEED 12'h004
`define DSTA_OFF_PEDAL 12'h008
`define DSTA_OFF_CREEP 12'h00c
`define DSTA_OFF_REGEN 12'h010
`define DSTA_OFF_CAP 12'h014
`define DSTA_OFF_DERATE 12'h018
`define DSTA_OFF_RATE 12'h01c
`define DSTA_OFF_MAPS 12'h020
`define DSTA_OFF_STATUS 12'h024
`define DSTA_OFF_TORQUE 12'h028
`define DSTA_FULL_SCALE 10'h100
`define DSTA_SPD_ZERO_RST 16'h0002
`define DSTA_SPD_LO_RST 16'h000a
`define DSTA_CAP_RST 16'h0190
`define DSTA_RATE_RST 16'h0010
`endif

// File: inc/dsta_pkg.sv
package dsta_pkg;
  typedef enum logic [1:0] {
    DSTA_PARK = 2'h0, DSTA_REV = 2'h1, DSTA_NEUT = 2'h2, DSTA_DRIVE = 2'h3
  } dsta_mode_e;
  typedef struct packed {
    logic insulation_fault;
    logic brake_pressed;
    logic charge_plug_present;
    logic [1:0] mode_request;
    logic [7:0] pedal_position;
    logic [15:0] vehicle_speed;
    logic [15:0] motor_speed;
    logic [15:0] dc_voltage;
    logic [7:0] regen_axis_input_a;
    logic [7:0] regen_axis_input_b;
  } dsta_sense_s;
endpackage

// File: tb/dsta_inverter_model.sv
`timescale 1ns/1ps
// ======================================================================
// Inverter model that takes the torque request every cycle.
module dsta_inverter_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] torque_request,
  output logic [15:0] motor_speed
);
  // A positive request spins the shaft up and a negative one slows it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_speed <= 16'h0000;
    end else if (!torque_request[15] && torque_request != 16'h0000) begin
      motor_speed <= motor_speed + 16'h0001;
    end else if (torque_request[15] && motor_speed != 16'h0000) begin
      motor_speed <= motor_speed - 16'h0001;
    end
  end
endmodule

// File: tb/dsta_arbiter_properties.sv
`timescale 1ns/1ps
// ======================================================================
// Interlock checker on the ports of the arbiter.
module dsta_arbiter_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dsta_pkg::dsta_sense_s sense,
  input wire logic [9:0] ext_hi_derate,
  input wire logic [9:0] ext_lo_derate,
  input wire logic [15:0] final_torque_command,
  input wire logic [4:0] op_state,
  input wire logic [1:0] drive_mode,
  input wire logic start_safe,
  input wire logic [1:0] run_mode_state
);
  import dsta_pkg::*;
  logic [5:0] brk_h;
  logic [5:0] plug_h;
  logic [5:0] flt_h;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Recent input history covers the synchroniser lag.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_h <= 6'h00;
      plug_h <= 6'h3f;
      flt_h <= 6'h3f;
    end else begin
      brk_h <= {brk_h[4:0], sense.brake_pressed};
      plug_h <= {plug_h[4:0], sense.charge_plug_present};
      flt_h <= {flt_h[4:0], sense.insulation_fault};
    end
  end
  a_state_range: assert property (
    op_state >= 5'h01 && op_state <= 5'h10) else $error("bad op_state");
  a_run_values: assert property (
    run_mode_state == 2'h0 || run_mode_state == 2'h2)
    else $error("bad run mode value");
  a_run_after_safe: assert property (
    start_safe && run_mode_state == 2'h0 |-> ##[1:3] run_mode_state == 2'h2)
    else $error("run mode did not follow start safe");
  a_idle_zero: assert property (
    run_mode_state == 2'h0 && $past(run_mode_state) == 2'h0
    |-> final_torque_command == 16'h0000) else $error("torque before run");
  a_park_brake: assert property (
    $past(drive_mode) == DSTA_PARK && drive_mode != DSTA_PARK |-> |brk_h)
    else $error("left park without brake");
  a_park_plug: assert property (
    ($past(drive_mode) == DSTA_PARK) != (drive_mode == DSTA_PARK)
    |-> !(&plug_h)) else $error("park change with plug present");
  a_safe_mode: assert property (
    start_safe |-> $past(drive_mode) inside {DSTA_PARK, DSTA_NEUT})
    else $error("start safe outside park or neutral");
  a_safe_inputs: assert property (
    $rose(start_safe) |-> |brk_h && !(&plug_h) && !(&flt_h))
    else $error("start safe without its inputs");
endmodule

bind dsta_arbiter dsta_arbiter_properties u_props (.sys_clk, .rst_n,
  .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .sense, .ext_hi_derate, .ext_lo_derate, .final_torque_command,
  .op_state, .drive_mode, .start_safe, .run_mode_state);

// File: tb/drive_state_torque_arbiter_bench.sv
`timescale 1ns/1ps
`include "dsta_regs.svh"
`define CHK(nm, ex, got) begin \
  n_tests++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end

module drive_state_torque_arbiter_bench;
  import dsta_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dsta_sense_s sense;
  logic [9:0] ext_hi_derate;
  logic [9:0] ext_lo_derate;
  logic [15:0] final_torque_command;
  logic [4:0] op_state;
  logic [1:0] drive_mode;
  logic start_safe;
  logic [1:0] run_mode_state;
  logic [15:0] inv_speed;
  logic [31:0] rd;
  logic er;
  int fails;
  int n_tests;
  int seed_v;

  dsta_arbiter u_dut (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .sense, .ext_hi_derate,
    .ext_lo_derate, .final_torque_command, .op_state, .drive_mode,
    .start_safe, .run_mode_state);
  dsta_inverter_model u_inv (.sys_clk, .rst_n,
    .torque_request(final_torque_command), .motor_speed(inv_speed));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) sense.motor_speed <= inv_speed;

  // ====================================================================
  // Tasks and expectations.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sns(input logic f, input logic b, input logic p,
                     input logic [1:0] m, input logic [7:0] ped,
                     input logic [15:0] spd);
    @(posedge sys_clk);
    sense.insulation_fault <= f;
    sense.brake_pressed <= b;
    sense.charge_plug_present <= p;
    sense.mode_request <= m;
    sense.pedal_position <= ped;
    sense.vehicle_speed <= spd;
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic step(input logic b, input logic p, input logic [1:0] m,
                      input logic [15:0] spd, input logic [1:0] em);
    sns(1'b0, b, p, m, 8'h20, spd);
    `CHK("drive_mode", em, drive_mode)
    if (em[0] == 1'b0) begin
      `CHK("torque_idle", 16'h0000, final_torque_command)
    end
  endtask

  function automatic logic exp_safe(logic f, logic b, logic p,
                                    logic [7:0] ped);
    return !f && b && !p && ped >= 8'h10 && ped <= 8'hc0;
  endfunction

  // ====================================================================
  // Main sequence.
  initial begin
    logic f;
    logic b;
    logic p;
    logic [7:0] ped;
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sense = '0;
    sense.dc_voltage = 16'h0190;
    sense.regen_axis_input_a = 8'h40;
    sense.regen_axis_input_b = 8'h80;
    ext_hi_derate = 10'h100;
    ext_lo_derate = 10'h100;
    seed_v = $urandom(32'h0931);
    repeat (8) @(posedge sys_clk);
    `CHK("op_state", 5'h01, op_state)
    `CHK("torque_rst", 16'h0000, final_torque_command)
    rst_n <= 1'b1;
    apb(1'b1, `DSTA_OFF_CTRL, 32'h0000_0004);
    apb(1'b1, `DSTA_OFF_SPEED, 32'h000c_0003);
    apb(1'b1, `DSTA_OFF_PEDAL, 32'h0508_10c0);
    apb(1'b1, `DSTA_OFF_CAP, 32'h00c8_00c8);
    apb(1'b1, `DSTA_OFF_DERATE, 32'h0100_0100);
    apb(1'b1, `DSTA_OFF_RATE, 32'h00ff_00ff);
    apb(1'b1, `DSTA_OFF_MAPS, 32'h0100_0064);
    apb(1'b1, `DSTA_OFF_CREEP, 32'hffff_fff0);
    apb(1'b1, `DSTA_OFF_STATUS, 32'hffff_0000);
    for (int lv = 0; lv < 4; lv++) begin
      apb(1'b1, `DSTA_OFF_TORQUE, {14'h0000, 2'(lv), 16'h0100});
    end
    apb(1'b0, `DSTA_OFF_SPEED, 32'h0000_0000);
    `CHK("speed_reg", 32'h000c_0003, rd)
    apb(1'b0, 12'h02c, 32'h0000_0000);
    `CHK("apb_error", 1'b1, er)
    for (int i = 0; i < 16; i++) begin
      f = ($urandom_range(3) == 0);
      b = ($urandom_range(3) != 0);
      p = ($urandom_range(3) == 0);
      ped = 8'($urandom);
      if (i < 4) begin
        f = 1'b0;
        b = 1'b1;
        p = 1'b0;
        ped = (i == 0) ? 8'h10 : (i == 1) ? 8'hc0 :
              (i == 2) ? 8'h0f : 8'hc1;
      end
      sns(f, b, p, 2'h0, ped, 16'h0000);
      `CHK("start_safe", exp_safe(f, b, p, ped), start_safe)
    end
    sns(1'b0, 1'b1, 1'b0, 2'h0, 8'h20, 16'h0000);
    `CHK("run_mode", 2'h2, run_mode_state)
    step(1'b0, 1'b0, 2'h3, 16'h0000, 2'h0);
    step(1'b1, 1'b1, 2'h3, 16'h0000, 2'h0);
    step(1'b1, 1'b0, 2'h3, 16'h0014, 2'h0);
    step(1'b1, 1'b0, 2'h2, 16'h0000, 2'h2);
    step(1'b1, 1'b0, 2'h3, 16'h0014, 2'h2);
    step(1'b1, 1'b0, 2'h3, 16'h0005, 2'h3);
    step(1'b0, 1'b0, 2'h0, 16'h0005, 2'h3);
    step(1'b0, 1'b0, 2'h1, 16'h0000, 2'h1);
    step(1'b0, 1'b0, 2'h3, 16'h0000, 2'h3);
    sns(1'b0, 1'b0, 1'b0, 2'h3, 8'hff, 16'h0000);
    repeat (50) @(posedge sys_clk);
    `CHK("torque_pos", 1'b1, $signed(final_torque_command) > 0)
    `CHK("torque_base", 16'h0064, final_torque_command)
    `CHK("torque_max", 1'b1, $signed(final_torque_command) <= 200)
    apb(1'b1, `DSTA_OFF_CAP, 32'h00c8_0020);
    repeat (50) @(posedge sys_clk);
    `CHK("torque_cap", 1'b1, $signed(final_torque_command) <= 32)
    `CHK("torque_cap_val", 16'h0020, final_torque_command)
    @(posedge sys_clk);
    ext_hi_derate <= 10'h000;
    repeat (50) @(posedge sys_clk);
    `CHK("derate_ext", 16'h0000, final_torque_command)
    @(posedge sys_clk);
    ext_hi_derate <= 10'h100;
    apb(1'b1, `DSTA_OFF_DERATE, 32'h0100_0000);
    repeat (50) @(posedge sys_clk);
    `CHK("derate_reg", 16'h0000, final_torque_command)
    apb(1'b1, `DSTA_OFF_DERATE, 32'h0100_0100);
    apb(1'b1, `DSTA_OFF_CAP, 32'h00c8_00c8);
    apb(1'b1, `DSTA_OFF_STATUS, 32'hffff_2030);
    apb(1'b1, `DSTA_OFF_CREEP, 32'h0080_0100);
    apb(1'b1, `DSTA_OFF_CTRL, 32'h0000_000c);
    sns(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, 16'h0000);
    `CHK("creep_on", 16'h0030, final_torque_command)
    sns(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, 16'h0120);
    `CHK("creep_off", 16'h0064, final_torque_command)
    sns(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, 16'h00c0);
    `CHK("creep_hyst", 16'h0064, final_torque_command)
    sns(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, 16'h0040);
    `CHK("creep_back", 16'h0030, final_torque_command)
    step(1'b0, 1'b0, 2'h1, 16'h0000, 2'h1);
    `CHK("torque_rev", 16'hffe0, final_torque_command)
    apb(1'b1, `DSTA_OFF_RATE, 32'h00ff_0004);
    step(1'b0, 1'b0, 2'h3, 16'h0000, 2'h3);
    `CHK("rise_slow", 1'b1, $signed(final_torque_command) < 100)
    repeat (40) @(posedge sys_clk);
    `CHK("rise_done", 16'h0064, final_torque_command)
    apb(1'b1, `DSTA_OFF_TORQUE, 32'h0001_0080);
    apb(1'b1, `DSTA_OFF_CTRL, 32'h0000_0005);
    repeat (20) @(posedge sys_clk);
    `CHK("pedal_level", 16'h0032, final_torque_command)
    apb(1'b1, `DSTA_OFF_MAPS, 32'h0080_0064);
    repeat (20) @(posedge sys_clk);
    `CHK("trim_half", 16'h0019, final_torque_command)
    step(1'b0, 1'b0, 2'h0, 16'h0001, 2'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("op_state_rst", 5'h01, op_state)
    `CHK("mode_rst", 2'h0, drive_mode)
    `CHK("torque_rst2", 16'h0000, final_torque_command)
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    end_of_test();
  end
endmodule
